// *** verilog/port_d_e_io.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1: Bank D direction bit one tristates the pin driver, making it an input.
// R2: Bank D direction bit zero drives the output latch onto the pin.
// R3: Bank D direction resets to all ones.
// R4: Bank D latch register reads return latch contents, not pins.
// R5: Control bit 4 selects slave-port mode for bank D.
// R6: Bank E pins each have a direction bit; one input, zero drives latch.
// R7: Bank E latch register reads return latch contents.
// R8: Bank E pins configured analog read as zero.
// R9: Bank E direction still controls drivers while pins are analog.
// R10: Bank E pins are analog after reset.
// R11: Input-full flag bit 7 shows an unread external byte; resets zero.
// R12: Output-full flag bit 6 shows a CPU byte not yet read externally.
// R13: Input-overrun bit 5 sets on write while input full; software clears.
// R14: Control bit 3 reads as zero.
// R15: Selected low read strobe makes the device drive bank D register out.
// R16: Selected low write strobe loads bank D register from the bus.
// R17: Chip select is active low; deselected strobes are ignored.
// R18: External write is recognised when select and write first both low.
// R19: External read is recognised when select and read first both low.
// R20: Software sets bank E to digital inputs before slave-port use.
// R21: Input-full sets on external write, clears on CPU read of bank D.
// R22: Output-full sets on CPU write in slave mode, clears on external read.
module port_d_e_io #(
  parameter int PORT_D_WIDTH = 8,
  parameter int PORT_E_WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bank D pins
  input wire logic [PORT_D_WIDTH-1:0] bankDIn,
  output logic [PORT_D_WIDTH-1:0] bankDOut,
  output logic [PORT_D_WIDTH-1:0] bankDOutEn_n,
  // Bank E pins
  input wire logic [PORT_E_WIDTH-1:0] bankEIn,
  output logic [PORT_E_WIDTH-1:0] bankEOut,
  output logic [PORT_E_WIDTH-1:0] bankEOutEn_n
);

  // Widths are fixed by the register layout, so other values are refused
  if (PORT_D_WIDTH != 8 || PORT_E_WIDTH != 3)
  begin
    $error("port_d_e_io serves only an 8-bit and a 3-bit bank");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] bankDLatch_q;
  logic [7:0] bankDDir_q;
  logic [2:0] bankELatch_q;
  logic [2:0] bankEDir_q;
  logic slaveSelect_q;
  logic inputFull_q;
  logic outputFull_q;
  logic inputOverrun_q;
  logic [3:0] convConfig_q;
  logic [7:0] slaveInByte_q;
  port_de_pkg::strobe_state_type wrState_q;
  port_de_pkg::strobe_state_type rdState_q;

  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic mapped;
  logic extWrite;
  logic extRead;
  logic extWriteLevel;
  logic extReadLevel;
  logic [2:0] bankEDigital;
  logic [7:0] readData;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a[11:2] == b[11:2]);
  endfunction

  assign apbAccess = psel && penable;
  // Side effects only in the first access cycle, so a held access cannot act twice
  assign apbWrite = apbAccess && pwrite && !pready;
  assign apbRead = apbAccess && !pwrite && !pready;

  // ****************************************
  // Slave-port strobe detection
  // ****************************************
  // Strobes are only honoured in slave mode; chip select low selects [R17]
  assign extWriteLevel = slaveSelect_q && !bankEIn[port_de_pkg::CHIP_SELECT_PIN]
    && !bankEIn[port_de_pkg::WRITE_STROBE_PIN];
  assign extReadLevel = slaveSelect_q && !bankEIn[port_de_pkg::CHIP_SELECT_PIN]
    && !bankEIn[port_de_pkg::READ_STROBE_PIN];
  // One event per strobe, on the first cycle both are seen low [R18] [R19]
  assign extWrite = extWriteLevel && (wrState_q == port_de_pkg::STROBE_IDLE);
  assign extRead = extReadLevel && (rdState_q == port_de_pkg::STROBE_IDLE);

  // A strobe held low yields one event; it must be seen high again to rearm
  function automatic port_de_pkg::strobe_state_type nextStrobe(
    input port_de_pkg::strobe_state_type cur,
    input logic level
  );
    case (cur)
      port_de_pkg::STROBE_IDLE:
        nextStrobe = level ? port_de_pkg::STROBE_ACTIVE : port_de_pkg::STROBE_IDLE;
      port_de_pkg::STROBE_ACTIVE:
        nextStrobe = level ? port_de_pkg::STROBE_ACTIVE : port_de_pkg::STROBE_IDLE;
      default:
        nextStrobe = port_de_pkg::STROBE_IDLE;
    endcase
  endfunction

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      wrState_q <= port_de_pkg::STROBE_IDLE;
    else
      wrState_q <= nextStrobe(wrState_q, extWriteLevel); // [R18]
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rdState_q <= port_de_pkg::STROBE_IDLE;
    else
      rdState_q <= nextStrobe(rdState_q, extReadLevel); // [R19]
  end

  // Bank D data from the external master lands here [R16]
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      slaveInByte_q <= port_de_pkg::LATCH_RESET;
    else if (extWrite)
      slaveInByte_q <= bankDIn;
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bankDLatch_q <= port_de_pkg::LATCH_RESET;
      bankELatch_q <= port_de_pkg::LATCH_RESET[2:0];
      bankDDir_q <= port_de_pkg::BANK_D_DIRECTION_RESET; // [R3]
      bankEDir_q <= port_de_pkg::BANK_E_DIRECTION_RESET;
      slaveSelect_q <= 1'b0;
      convConfig_q <= port_de_pkg::CONVERTER_CONFIG_RESET; // [R10]
    end
    else if (apbWrite)
    begin
      if (hit(paddr, port_de_pkg::BANK_D_PIN_DATA_ADDR)
          || hit(paddr, port_de_pkg::BANK_D_OUTPUT_LATCH_ADDR))
        bankDLatch_q <= pwdata[7:0];
      if (hit(paddr, port_de_pkg::BANK_E_PIN_DATA_ADDR)
          || hit(paddr, port_de_pkg::BANK_E_OUTPUT_LATCH_ADDR))
        bankELatch_q <= pwdata[2:0];
      if (hit(paddr, port_de_pkg::BANK_D_DIRECTION_ADDR))
        bankDDir_q <= pwdata[7:0];
      if (hit(paddr, port_de_pkg::BANK_E_CTRL_ADDR))
      begin
        bankEDir_q <= pwdata[2:0];
        slaveSelect_q <= pwdata[port_de_pkg::SLAVE_SELECT_BIT]; // [R5]
      end
      if (hit(paddr, port_de_pkg::CONVERTER_PIN_CONFIG_ADDR))
        convConfig_q <= pwdata[3:0];
    end
  end

  // ****************************************
  // Slave-port status flags
  // ****************************************
  logic cpuReadD;
  logic cpuWriteD;
  assign cpuReadD = apbRead && hit(paddr, port_de_pkg::BANK_D_PIN_DATA_ADDR);
  assign cpuWriteD = apbWrite && slaveSelect_q
    && hit(paddr, port_de_pkg::BANK_D_PIN_DATA_ADDR);

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      inputFull_q <= 1'b0; // [R11]
      outputFull_q <= 1'b0;
      inputOverrun_q <= 1'b0;
    end
    else
    begin
      if (extWrite)
        inputFull_q <= 1'b1; // [R21]
      else if (cpuReadD)
        inputFull_q <= 1'b0; // [R21]
      if (cpuWriteD)
        outputFull_q <= 1'b1; // [R22] [R12]
      else if (extRead)
        outputFull_q <= 1'b0; // [R22]
      if (extWrite && inputFull_q)
        inputOverrun_q <= 1'b1; // [R13]
      else if (apbWrite && hit(paddr, port_de_pkg::BANK_E_CTRL_ADDR)
               && !pwdata[port_de_pkg::INPUT_OVERRUN_BIT])
        inputOverrun_q <= 1'b0; // [R13]
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Slave mode turns bank D around under the external read strobe [R15]
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bankDOut <= port_de_pkg::LATCH_RESET;
      bankDOutEn_n <= port_de_pkg::BANK_D_DIRECTION_RESET;
      bankEOut <= port_de_pkg::LATCH_RESET[2:0];
      bankEOutEn_n <= port_de_pkg::BANK_E_DIRECTION_RESET;
    end
    else
    begin
      bankDOut <= bankDLatch_q; // [R2]
      if (slaveSelect_q)
        bankDOutEn_n <= extReadLevel ? 8'h00 : 8'hff; // [R15]
      else
        bankDOutEn_n <= bankDDir_q; // [R1] [R2]
      bankEOut <= bankELatch_q;
      // Direction rules even for analog pins; software must keep inputs [R6] [R9]
      bankEOutEn_n <= bankEDir_q;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Simplified converter map: a field of 7 or more makes all pins digital
  assign bankEDigital = (convConfig_q[2:0] >= port_de_pkg::ALL_DIGITAL_CONFIG)
    ? 3'h7 : 3'h0;
  assign mapped = paddr[11:2] <= port_de_pkg::CONVERTER_PIN_CONFIG_ADDR[11:2];

  always_comb
  begin
    readData = 8'h00;
    if (hit(paddr, port_de_pkg::BANK_D_PIN_DATA_ADDR))
      readData = slaveSelect_q ? slaveInByte_q : bankDIn;
    else if (hit(paddr, port_de_pkg::BANK_D_OUTPUT_LATCH_ADDR))
      readData = bankDLatch_q; // [R4]
    else if (hit(paddr, port_de_pkg::BANK_D_DIRECTION_ADDR))
      readData = bankDDir_q;
    else if (hit(paddr, port_de_pkg::BANK_E_PIN_DATA_ADDR))
      readData = {5'h00, bankEIn & bankEDigital}; // [R8]
    else if (hit(paddr, port_de_pkg::BANK_E_OUTPUT_LATCH_ADDR))
      readData = {5'h00, bankELatch_q}; // [R7]
    else if (hit(paddr, port_de_pkg::BANK_E_CTRL_ADDR))
      readData = {inputFull_q, outputFull_q, inputOverrun_q, slaveSelect_q,
                  1'b0, bankEDir_q}; // [R14] [R11] [R12]
    else if (hit(paddr, port_de_pkg::CONVERTER_PIN_CONFIG_ADDR))
      readData = {4'h0, convConfig_q};
  end

  // Answer one cycle into the access phase; pready pulses for a single cycle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apbAccess && !pready;
      pslverr <= apbAccess && !pready && !mapped;
      prdata <= (apbRead && !pready) ? {24'h000000, readData} : 32'h00000000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence extWriteSeen;
    extWrite;
  endsequence

  property dirResetP;
    @(posedge clk_sys) $fell(reset) |-> bankDDir_q == 8'hff;
  endproperty
  dir_reset_a: assert property (dirResetP) else $error("bank D direction not all ones"); // [R3]

  dir_drive_a: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    !slaveSelect_q && !$past(slaveSelect_q) |-> bankDOutEn_n == $past(bankDDir_q))
    else $error("bank D enable does not follow direction");
  full_set_a: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    extWriteSeen |=> inputFull_q) else $error("input full not set");
  overrun_set_a: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
    extWrite && inputFull_q |=> inputOverrun_q) else $error("overrun not set");
  obf_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // [R22]
    extRead && !cpuWriteD |=> !outputFull_q) else $error("output full not cleared");
  deselect_ignore_a: assert property (@(posedge clk_sys) disable iff (reset) // [R17]
    bankEIn[2] |-> !extWrite && !extRead) else $error("strobe accepted while deselected");
  first_edge_a: assert property (@(posedge clk_sys) disable iff (reset) // [R18]
    extWrite |=> !extWrite) else $error("write recognised twice");
  analog_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    convConfig_q[2:0] != 3'h7 |-> readData[2:0] == 3'h0
      || !hit(paddr, port_de_pkg::BANK_E_PIN_DATA_ADDR))
    else $error("analog pin read nonzero");

  // ****************************************
  // Register, pin and slave-port checks
  // ****************************************
  sequence latchDRead;
    apbRead && hit(paddr, port_de_pkg::BANK_D_OUTPUT_LATCH_ADDR);
  endsequence

  sequence latchERead;
    apbRead && hit(paddr, port_de_pkg::BANK_E_OUTPUT_LATCH_ADDR);
  endsequence

  sequence ctrlRead;
    apbRead && hit(paddr, port_de_pkg::BANK_E_CTRL_ADDR);
  endsequence

  sequence extReadSeen;
    extRead;
  endsequence

  sequence overrunKept;
    inputOverrun_q && !(apbWrite && hit(paddr, port_de_pkg::BANK_E_CTRL_ADDR)
      && !pwdata[port_de_pkg::INPUT_OVERRUN_BIT]);
  endsequence

  latch_drive_a: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
    bankDOut == $past(bankDLatch_q))
    else $error("bank D pins do not show the latch");
  e_drive_a: assert property (@(posedge clk_sys) disable iff (reset) // [R6] [R9]
    bankEOutEn_n == $past(bankEDir_q) && bankEOut == $past(bankELatch_q))
    else $error("bank E drivers do not follow direction and latch");
  d_latch_read_a: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    latchDRead |=> prdata[7:0] == $past(bankDLatch_q))
    else $error("latch D read wrong");
  e_latch_read_a: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    latchERead |=> prdata[2:0] == $past(bankELatch_q))
    else $error("latch E read wrong");
  ctrl_gap_a: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
    ctrlRead |=> !prdata[3])
    else $error("control bit 3 read nonzero");
  slave_drive_a: assert property (@(posedge clk_sys) disable iff (reset) // [R15]
    slaveSelect_q && extReadLevel |=> bankDOutEn_n == 8'h00)
    else $error("slave read not driven");
  slave_capture_a: assert property (@(posedge clk_sys) disable iff (reset) // [R16]
    extWriteSeen |=> slaveInByte_q == $past(bankDIn))
    else $error("slave write not captured");
  read_once_a: assert property (@(posedge clk_sys) disable iff (reset) // [R19]
    extReadSeen |=> !extRead)
    else $error("read recognised twice");
  obf_set_a: assert property (@(posedge clk_sys) disable iff (reset) // [R22] [R12]
    cpuWriteD |=> outputFull_q)
    else $error("output full not set");
  ibf_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    cpuReadD && !extWrite |=> !inputFull_q)
    else $error("input full not cleared");
  overrun_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
    overrunKept |=> inputOverrun_q)
    else $error("overrun lost without a clear");
  mode_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
    !slaveSelect_q |-> !extWrite && !extRead)
    else $error("strobe honoured in port mode");

endmodule

// *** pkg/port_de_pkg.sv ***
package port_de_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [11:0] BANK_D_PIN_DATA_ADDR = 12'h000;
  localparam logic [11:0] BANK_D_OUTPUT_LATCH_ADDR = 12'h004;
  localparam logic [11:0] BANK_D_DIRECTION_ADDR = 12'h008;
  localparam logic [11:0] BANK_E_PIN_DATA_ADDR = 12'h00c;
  localparam logic [11:0] BANK_E_OUTPUT_LATCH_ADDR = 12'h010;
  localparam logic [11:0] BANK_E_CTRL_ADDR = 12'h014;
  localparam logic [11:0] CONVERTER_PIN_CONFIG_ADDR = 12'h018;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INPUT_FULL_BIT = 7;
  localparam int OUTPUT_FULL_BIT = 6;
  localparam int INPUT_OVERRUN_BIT = 5;
  localparam int SLAVE_SELECT_BIT = 4;
  localparam int READ_STROBE_PIN = 0;
  localparam int WRITE_STROBE_PIN = 1;
  localparam int CHIP_SELECT_PIN = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] BANK_D_DIRECTION_RESET = 8'hff;
  localparam logic [2:0] BANK_E_DIRECTION_RESET = 3'h7;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [3:0] CONVERTER_CONFIG_RESET = 4'h0;
  // Field values at or above this make all three bank E pins digital
  localparam logic [2:0] ALL_DIGITAL_CONFIG = 3'h7;

  typedef enum logic [1:0]
  {
    STROBE_IDLE = 2'b00,
    STROBE_ACTIVE = 2'b01
  } strobe_state_type;

endpackage

// *** verification/ext_cpu_model.sv ***
`timescale 1ns/1ps
// ************************************
// External byte-wide master and pins
// ************************************
module ext_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Device pins
  input wire logic [7:0] bankDOut,
  input wire logic [7:0] bankDOutEn_n,
  input wire logic [2:0] bankEOut,
  input wire logic [2:0] bankEOutEn_n,
  output logic [7:0] bankDIn,
  output logic [2:0] bankEIn
);
  logic [7:0] busData = 8'h00;
  logic busDrive = 1'b0;
  // Order is chip select, write, read; all idle high
  logic [2:0] strobe_n = 3'h7;
  logic [7:0] extLevel;
  // A released bus shows the inverse so a stale byte never passes for fresh data
  assign extLevel = busDrive ? busData : ~busData;
  assign bankDIn = (bankDOutEn_n & extLevel) | (~bankDOutEn_n & bankDOut);
  assign bankEIn = (bankEOutEn_n & strobe_n) | (~bankEOutEn_n & bankEOut);

  task automatic drive_pins(input logic [7:0] value);
    busData <= value;
    busDrive <= 1'b1;
  endtask

  task automatic ext_write(input logic [7:0] value, input logic sel_n);
    busData <= value;
    busDrive <= 1'b1;
    strobe_n <= {sel_n, 2'b01};
    repeat (2) @(posedge clk_sys);
    strobe_n <= 3'h7;
    @(posedge clk_sys);
    busDrive <= 1'b0;
  endtask

  task automatic ext_read(output logic [7:0] value);
    strobe_n <= 3'b010;
    repeat (2) @(posedge clk_sys);
    value = bankDIn;
    strobe_n <= 3'h7;
    @(posedge clk_sys);
  endtask
endmodule

// *** verification/port_d_e_io_with_slave_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ************************************
// Bench for the bank D and E ports
// ************************************
module port_d_e_io_with_slave_ctrl_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] bankDIn, bankDOut, bankDOutEn_n, extByte;
  logic [2:0] bankEIn, bankEOut, bankEOutEn_n;
  logic [31:0] rd;
  logic rdErr;
  int n_mismatch = 0;
  int num_checks = 0;

  always #4 clk_sys = ~clk_sys;

  port_d_e_io u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bankDIn(bankDIn), .bankDOut(bankDOut), .bankDOutEn_n(bankDOutEn_n),
    .bankEIn(bankEIn), .bankEOut(bankEOut), .bankEOutEn_n(bankEOutEn_n));
  ext_cpu_model u_cpu (.clk_sys(clk_sys), .bankDOut(bankDOut), .bankDOutEn_n(bankDOutEn_n),
    .bankEOut(bankEOut), .bankEOutEn_n(bankEOutEn_n), .bankDIn(bankDIn), .bankEIn(bankEIn));

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int waits = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && waits < 20)
    begin
      @(posedge clk_sys);
      waits++;
    end
    if (waits >= 20) n_mismatch++;
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic read_chk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    `CHK(rd, exp)
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ************************************
  // Directed sequence
  // ************************************
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK(bankDOutEn_n, 8'hff)
    `CHK(bankEOutEn_n, 3'h7)
    read_chk(port_de_pkg::BANK_D_DIRECTION_ADDR, 32'hff);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h07);
    read_chk(port_de_pkg::BANK_E_PIN_DATA_ADDR, 32'h0);
    u_cpu.drive_pins(8'h3c);
    apb(1'b1, port_de_pkg::BANK_D_OUTPUT_LATCH_ADDR, 32'ha5);
    apb(1'b1, port_de_pkg::BANK_D_DIRECTION_ADDR, 32'h0f);
    `CHK(bankDOutEn_n, 8'h0f)
    `CHK(bankDOut, 8'ha5)
    read_chk(port_de_pkg::BANK_D_OUTPUT_LATCH_ADDR, 32'ha5);
    read_chk(port_de_pkg::BANK_D_PIN_DATA_ADDR, 32'hac);
    apb(1'b1, port_de_pkg::BANK_E_OUTPUT_LATCH_ADDR, 32'h4);
    apb(1'b1, port_de_pkg::BANK_E_CTRL_ADDR, 32'h02);
    `CHK(bankEOutEn_n, 3'h2)
    `CHK(bankEOut, 3'h4)
    read_chk(port_de_pkg::BANK_E_OUTPUT_LATCH_ADDR, 32'h4);
    read_chk(port_de_pkg::BANK_E_PIN_DATA_ADDR, 32'h0);
    apb(1'b1, port_de_pkg::CONVERTER_PIN_CONFIG_ADDR, 32'h7);
    read_chk(port_de_pkg::BANK_E_PIN_DATA_ADDR, 32'h6);
    apb(1'b1, port_de_pkg::BANK_E_CTRL_ADDR, 32'h17);
    apb(1'b1, port_de_pkg::BANK_D_PIN_DATA_ADDR, 32'h5a);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h57);
    u_cpu.ext_read(extByte);
    `CHK(extByte, 8'h5a)
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h17);
    u_cpu.ext_write(8'h81, 1'b1);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h17);
    u_cpu.ext_write(8'h81, 1'b0);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h97);
    u_cpu.ext_write(8'h42, 1'b0);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'hb7);
    read_chk(port_de_pkg::BANK_D_PIN_DATA_ADDR, 32'h42);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h37);
    apb(1'b1, port_de_pkg::BANK_E_CTRL_ADDR, 32'hf7);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h37);
    apb(1'b1, port_de_pkg::BANK_E_CTRL_ADDR, 32'h17);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h17);
    apb(1'b1, port_de_pkg::BANK_E_CTRL_ADDR, 32'h07);
    u_cpu.ext_write(8'h99, 1'b0);
    read_chk(port_de_pkg::BANK_E_CTRL_ADDR, 32'h07);
    apb(1'b0, 12'h01c, 32'h0);
    `CHK(rdErr, 1'b1)
    test_done();
  end

  // Cuts a hang short well past the expected run length
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
endmodule
